// ===== shared/fe_coding_defines.vh
`ifndef FE_CODING_DEFINES_VH
`define FE_CODING_DEFINES_VH
// Control code-groups
`define CG_IDLE 5'h1F
`define CG_J 5'h18
`define CG_K 5'h11
`define CG_T 5'h0D
`define CG_R 5'h07
`define CG_H 5'h04
// Nibble reported for start-of-stream and bad start-of-stream
`define NIB_SSD 4'h5
`define NIB_BAD_SSD 4'hE
// Scrambler seed and taps
`define SCR_SEED 11'h7_FF
`define SCR_TAP_A 10
`define SCR_TAP_B 8
// MLT-3 levels: 2'b00 middle, 2'b01 plus, 2'b11 minus
`define MLT_MID 2'h0
`define MLT_POS 2'h1
`define MLT_NEG 2'h3
// Clock rates in kHz, and bits per code-group
`define CORE_CLK_KHZ 20000
`define BIT_RATE_KHZ 125000
`define SYM_BITS 5
`endif

// ===== src/fe_symbol_coding.v
`timescale 1ns/100ps
`include "fe_coding_defines.vh"

// Overview of operation
// RULE_01: Nibbles map to fixed 5-bit data code-groups; decoder inverts the mapping.
// RULE_02: A bypass bit skips encoding; fifth bit then carries transmit error.
// RULE_03: Idle code-groups follow an end-of-stream pair until transmit enable returns.
// RULE_04: Rising transmit enable sends J then K before frame data.
// RULE_05: J after idle and K after J decode to 0101; elsewhere error.
// RULE_06: Falling transmit enable sends T then R.
// RULE_07: T followed by R drops carrier sense; T without R raises error.
// RULE_08: R after T drops carrier sense; R elsewhere raises error.
// RULE_09: Transmit error replaces data with the H code-group.
// RULE_10: Undefined code-groups are never sent; received during data valid raise error.
// RULE_11: Every code-group, idle included, is scrambled before line coding.
// RULE_12: The scrambler stage also serialises the 5-bit code-groups.
// RULE_13: Serial bits become an NRZI stream at the bit rate.
// RULE_14: MLT-3: a one steps to the next level, a zero holds.
// RULE_15: Transmit coding runs from the PLL-made coding clock.
// RULE_16: Receive takes one 6-bit quantizer sample per cycle.
// RULE_17: Recovered clock phase is chosen by a multiplexer over several phases.
// RULE_18: Recovered MLT-3 levels convert back into an NRZI stream.
// RULE_19: Scrambler is the 11-bit x^11+x^9+1 cipher, seeded non-zero.
// RULE_20: After reset, idle only while enable low; MLT-3 starts at middle.
module fe_symbol_coding #(
    parameter PHASES = 4,
    parameter PHW = 2
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire bit_clk_i,
    input wire tx_en_i,
    input wire tx_er_i,
    input wire [3:0] txd_i,
    input wire enc_enable_i,
    input wire [5:0] adc_sample_i,
    input wire [PHASES-1:0] clk_phases_i,
    input wire [PHW-1:0] phase_sel_i,
    input wire [1:0] rx_mlt_i,
    input wire [4:0] rx_group_i,
    input wire rx_group_valid_i,
    output reg tx_ready_o,
    output reg [1:0] tx_mlt_o,
    output reg tx_nrzi_o,
    output reg [5:0] adc_sample_o,
    output reg rec_clk_o,
    output reg rx_nrzi_o,
    output reg [3:0] rxd_o,
    output reg rx_dv_o,
    output reg rx_er_o,
    output reg crs_o
);
    localparam [1:0] TS_IDLE = 2'h0, TS_K = 2'h1, TS_DATA = 2'h2, TS_R = 2'h3;

    // Data nibble to code-group table
    function [4:0] enc4b5b;
        input [3:0] n;
        begin
            case (n)
                4'h0: enc4b5b = 5'h1E;
                4'h1: enc4b5b = 5'h09;
                4'h2: enc4b5b = 5'h14;
                4'h3: enc4b5b = 5'h15;
                4'h4: enc4b5b = 5'h0A;
                4'h5: enc4b5b = 5'h0B;
                4'h6: enc4b5b = 5'h0E;
                4'h7: enc4b5b = 5'h0F;
                4'h8: enc4b5b = 5'h12;
                4'h9: enc4b5b = 5'h13;
                4'hA: enc4b5b = 5'h16;
                4'hB: enc4b5b = 5'h17;
                4'hC: enc4b5b = 5'h1A;
                4'hD: enc4b5b = 5'h1B;
                4'hE: enc4b5b = 5'h1C;
                default: enc4b5b = 5'h1D;
            endcase
        end
    endfunction

    // Inverse table; bit 4 flags a code-group that is no data
    function [4:0] dec5b4b;
        input [4:0] g;
        begin
            case (g)
                5'h1E: dec5b4b = 5'h00;
                5'h09: dec5b4b = 5'h01;
                5'h14: dec5b4b = 5'h02;
                5'h15: dec5b4b = 5'h03;
                5'h0A: dec5b4b = 5'h04;
                5'h0B: dec5b4b = 5'h05;
                5'h0E: dec5b4b = 5'h06;
                5'h0F: dec5b4b = 5'h07;
                5'h12: dec5b4b = 5'h08;
                5'h13: dec5b4b = 5'h09;
                5'h16: dec5b4b = 5'h0A;
                5'h17: dec5b4b = 5'h0B;
                5'h1A: dec5b4b = 5'h0C;
                5'h1B: dec5b4b = 5'h0D;
                5'h1C: dec5b4b = 5'h0E;
                5'h1D: dec5b4b = 5'h0F;
                default: dec5b4b = 5'h10;
            endcase
        end
    endfunction

    // Pin synchronisers; first stages read only by second stages
    reg bclk_s1_q;
    reg [1:0] bclk_s2_q;
    reg en_s1_q, en_s2_q, er_s1_q, er_s2_q;
    reg [3:0] txd_s1_q, txd_s2_q;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bclk_s1_q <= 1'b1; // High, so a clock already high at release is no edge
            bclk_s2_q <= 2'h3;
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            er_s1_q <= 1'b0;
            er_s2_q <= 1'b0;
            txd_s1_q <= 4'h0;
            txd_s2_q <= 4'h0;
        end else begin
            bclk_s1_q <= bit_clk_i;
            bclk_s2_q <= {bclk_s2_q[0], bclk_s1_q};
            en_s1_q <= tx_en_i;
            en_s2_q <= en_s1_q;
            er_s1_q <= tx_er_i;
            er_s2_q <= er_s1_q;
            txd_s1_q <= txd_i;
            txd_s2_q <= txd_s1_q;
        end
    end
    // Bit slots follow the sampled coding clock edges
    wire bit_tick = bclk_s2_q[0] & ~bclk_s2_q[1]; // RULE_15 RULE_13

    // Two-entry buffer between nibble intake and symbol generation; a full
    // buffer drops tx_ready_o a cycle later, and nibbles that reach it while full are dropped
    reg [4:0] buf_q [0:1];
    reg [1:0] cnt_q;
    reg rd_q, wr_q;
    reg en_d1_q;
    wire in_valid = en_s2_q | en_d1_q;
    wire in_ready = (cnt_q != 2'h2);
    wire sym_take;
    wire out_valid = (cnt_q != 2'h0);
    wire [4:0] out_word = buf_q[rd_q];
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 2'h0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            en_d1_q <= 1'b0;
            buf_q[0] <= 5'h00;
            buf_q[1] <= 5'h00;
        end else begin
            en_d1_q <= en_s2_q;
            if (in_valid && in_ready) begin
                buf_q[wr_q] <= {en_s2_q, er_s2_q, 3'h0};
                wr_q <= ~wr_q;
            end
            if (sym_take && out_valid)
                rd_q <= ~rd_q;
            cnt_q <= cnt_q + {1'b0, in_valid && in_ready}
                     - {1'b0, sym_take && out_valid};
        end
    end
    // Nibble data kept beside buffer flags (same slot index)
    reg [3:0] nib_q [0:1];
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nib_q[0] <= 4'h0;
            nib_q[1] <= 4'h0;
        end else if (in_valid && in_ready) begin
            nib_q[wr_q] <= txd_s2_q;
        end
    end

    // Symbol sequencer and serialiser
    reg [1:0] ts_q;
    reg [2:0] bit_idx_q;
    reg [4:0] shift_q;
    reg [10:0] scr_q;
    reg mlt_up_q; // Swing direction out of middle; alternating keeps 0,+,0,- order
    wire sym_end = bit_tick && (bit_idx_q == 3'h4);
    assign sym_take = sym_end && ((ts_q == TS_DATA) || (ts_q == TS_IDLE));
    wire buf_en = out_valid & out_word[4];
    wire buf_er = out_word[3];
    reg [4:0] next_sym;
    reg [1:0] ts_d;
    always @* begin
        next_sym = `CG_IDLE; // RULE_03 RULE_20
        ts_d = ts_q;
        case (ts_q)
            TS_IDLE: begin
                if (buf_en) begin
                    next_sym = `CG_J; // RULE_04
                    ts_d = TS_K;
                end
            end
            TS_K: begin
                next_sym = `CG_K; // RULE_04
                ts_d = TS_DATA;
            end
            TS_DATA: begin
                if (!buf_en) begin
                    next_sym = `CG_T; // RULE_06
                    ts_d = TS_R;
                end else if (!enc_enable_i) begin
                    next_sym = {buf_er, nib_q[rd_q]}; // RULE_02
                end else if (buf_er) begin
                    next_sym = `CG_H; // RULE_09
                end else begin
                    next_sym = enc4b5b(nib_q[rd_q]); // RULE_01 RULE_10
                end
            end
            default: begin
                next_sym = `CG_R; // RULE_06
                ts_d = TS_IDLE;
            end
        endcase
    end
    // Scrambler bit: x^11 + x^9 + 1 keystream added to each serial bit
    wire key_bit = scr_q[`SCR_TAP_A] ^ scr_q[`SCR_TAP_B]; // RULE_19
    wire ser_bit = shift_q[4] ^ key_bit; // RULE_11 RULE_12
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ts_q <= TS_IDLE;
            bit_idx_q <= 3'h0;
            shift_q <= `CG_IDLE;
            scr_q <= `SCR_SEED; // RULE_19
            tx_nrzi_o <= 1'b0;
            tx_mlt_o <= `MLT_MID; // RULE_20
            mlt_up_q <= 1'b1;
            tx_ready_o <= 1'b0;
        end else begin
            tx_ready_o <= in_ready;
            if (bit_tick) begin
                scr_q <= {scr_q[9:0], key_bit};
                if (bit_idx_q == 3'h4) begin
                    bit_idx_q <= 3'h0;
                    shift_q <= next_sym;
                    ts_q <= ts_d;
                end else begin
                    bit_idx_q <= bit_idx_q + 3'h1;
                    shift_q <= {shift_q[3:0], 1'b0};
                end
                // NRZI toggles on a one; MLT-3 steps on the same one
                if (ser_bit) begin
                    tx_nrzi_o <= ~tx_nrzi_o; // RULE_13
                    case (tx_mlt_o) // RULE_14
                        `MLT_MID: begin
                            tx_mlt_o <= mlt_up_q ? `MLT_POS : `MLT_NEG;
                            mlt_up_q <= ~mlt_up_q;
                        end
                        default: tx_mlt_o <= `MLT_MID;
                    endcase
                end
            end
        end
    end

    // Receive sample intake, phase select and MLT-3 to NRZI
    reg [1:0] rx_mlt_prev_q;
    reg [PHASES-1:0] ph_s1_q, ph_s2_q;
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            adc_sample_o <= 6'h00;
            ph_s1_q <= {PHASES{1'b0}};
            ph_s2_q <= {PHASES{1'b0}};
            rec_clk_o <= 1'b0;
            rx_mlt_prev_q <= `MLT_MID;
            rx_nrzi_o <= 1'b0;
        end else begin
            adc_sample_o <= adc_sample_i; // RULE_16
            ph_s1_q <= clk_phases_i;
            ph_s2_q <= ph_s1_q;
            rec_clk_o <= ph_s2_q[phase_sel_i]; // RULE_17
            rx_mlt_prev_q <= rx_mlt_i;
            rx_nrzi_o <= (rx_mlt_i != rx_mlt_prev_q); // RULE_18
        end
    end

    // Code-group interpreter
    reg [4:0] prev_grp_q;
    reg t_pend_q;
    wire [4:0] dec = dec5b4b(rx_group_i);
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_grp_q <= `CG_IDLE;
            t_pend_q <= 1'b0;
            rxd_o <= 4'h0;
            rx_dv_o <= 1'b0;
            rx_er_o <= 1'b0;
            crs_o <= 1'b0;
        end else if (rx_group_valid_i) begin
            prev_grp_q <= rx_group_i;
            t_pend_q <= (rx_group_i == `CG_T);
            rx_er_o <= 1'b0;
            if (t_pend_q && rx_group_i != `CG_R) begin
                rx_er_o <= 1'b1; // RULE_07
            end else if (rx_group_i == `CG_J) begin
                if (prev_grp_q == `CG_IDLE) begin
                    rxd_o <= `NIB_SSD; // RULE_05
                    crs_o <= 1'b1;
                end else begin
                    rxd_o <= `NIB_BAD_SSD;
                    rx_er_o <= 1'b1;
                end
            end else if (rx_group_i == `CG_K) begin
                if (prev_grp_q == `CG_J) begin
                    rxd_o <= `NIB_SSD; // RULE_05
                    rx_dv_o <= 1'b1;
                    crs_o <= 1'b1; // Data valid never stands without carrier
                end else begin
                    rxd_o <= `NIB_BAD_SSD;
                    rx_er_o <= 1'b1;
                end
            end else if (rx_group_i == `CG_R) begin
                if (prev_grp_q == `CG_T) begin
                    crs_o <= 1'b0; // RULE_07 RULE_08
                    rx_dv_o <= 1'b0;
                end else begin
                    rx_er_o <= 1'b1; // RULE_08
                end
            end else if (rx_group_i == `CG_T) begin
                rx_er_o <= 1'b0;
            end else if (rx_group_i == `CG_IDLE) begin
                if (prev_grp_q == `CG_IDLE) begin
                    crs_o <= 1'b0;
                    rx_dv_o <= 1'b0;
                end
            end else if (!dec[4]) begin
                rxd_o <= dec[3:0]; // RULE_01
            end else if (rx_dv_o) begin
                rx_er_o <= 1'b1; // RULE_10
            end
        end
    end
endmodule

// ===== verification/fe_coding_monitor.sv
`timescale 1ns/100ps
`include "fe_coding_defines.vh"
module fe_coding_monitor #(
    parameter PHASES = 4,
    parameter PHW = 2
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire [5:0] adc_sample_i,
    input wire [5:0] adc_sample_o,
    input wire [PHASES-1:0] clk_phases_i,
    input wire [PHW-1:0] phase_sel_i,
    input wire rec_clk_o,
    input wire [1:0] rx_mlt_i,
    input wire rx_nrzi_o,
    input wire [4:0] rx_group_i,
    input wire rx_group_valid_i,
    input wire [3:0] rxd_o,
    input wire rx_er_o,
    input wire rx_dv_o,
    input wire crs_o,
    input wire [1:0] tx_mlt_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Receive side relations, each but chk_dv_crs tied to its input one or more edges back
    chk_adc_copy: assert property (adc_sample_o == $past(adc_sample_i))
        else $error("quantizer sample not passed on");
    chk_rx_nrzi: assert property (rx_nrzi_o == ($past(rx_mlt_i) != $past(rx_mlt_i, 2)))
        else $error("receive nrzi bit wrong");
    chk_rec_phase: assert property (($past(phase_sel_i, 3) == phase_sel_i)
        |-> rec_clk_o == $past(clk_phases_i[phase_sel_i], 3)) else $error("wrong phase");
    chk_ssd_nibble: assert property (($past(rx_group_valid_i) && !rx_er_o
        && $past(rx_group_i) == `CG_K) |-> rxd_o == `NIB_SSD) else $error("bad ssd nibble");
    chk_er_cause: assert property ($rose(rx_er_o) |-> $past(rx_group_valid_i))
        else $error("error flag without a group");
    chk_rx_hold: assert property (!$past(rx_group_valid_i) |-> $stable(rxd_o) && $stable(crs_o))
        else $error("receive outputs moved without a group");
    chk_dv_crs: assert property (rx_dv_o |-> crs_o)
        else $error("data valid without carrier");
    // Line levels: three only, and no jump across the middle
    chk_mlt_legal: assert property (tx_mlt_o != 2'h2)
        else $error("illegal line level");
    chk_mlt_step: assert property ((tx_mlt_o != $past(tx_mlt_o))
        |-> (tx_mlt_o == `MLT_MID || $past(tx_mlt_o) == `MLT_MID)) else $error("level skipped");
endmodule

bind fe_symbol_coding fe_coding_monitor #(.PHASES(PHASES), .PHW(PHW)) u_mon (.core_clk_i,
    .rst_i, .adc_sample_i, .adc_sample_o, .clk_phases_i, .phase_sel_i, .rec_clk_o, .rx_mlt_i,
    .rx_nrzi_o, .rx_group_i, .rx_group_valid_i, .rxd_o, .rx_er_o, .rx_dv_o, .crs_o, .tx_mlt_o);

// ===== verification/fe_symbol_coding_tb.sv
`timescale 1ns/100ps
`include "fe_coding_defines.vh"
module fe_symbol_coding_tb;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bit_clk_i = 1'b0;
    logic enc_enable_i = 1'b1;
    logic mac_go = 1'b0;
    logic mac_err = 1'b0;
    logic tx_en_i, tx_er_i, tx_ready_o, tx_nrzi_o, rec_clk_o, rx_nrzi_o, rx_dv_o, rx_er_o, crs_o;
    logic [3:0] txd_i, rxd_o, r;
    logic [5:0] adc_sample_i = 6'h00;
    logic [5:0] adc_sample_o;
    logic [3:0] clk_phases_i = 4'h0;
    logic [1:0] phase_sel_i = 2'h0;
    logic [1:0] rx_mlt_i = 2'h0;
    logic [1:0] tx_mlt_o, last_mlt = 2'h0;
    logic [4:0] rx_group_i = 5'h00;
    logic rx_group_valid_i = 1'b0;
    logic seen_q = 1'b0;
    logic full_seen = 1'b0;
    logic [7:0] exq[$];
    logic [7:0] e;
    int error_cnt = 0, compares = 0, mlt_chg = 0, i, k;
    logic [4:0] dtab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic [4:0] bad [10] = '{5'h06, 5'h19, 5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h08,
        5'h0C, 5'h10};

    fe_symbol_coding #(.PHASES(4), .PHW(2)) dut (.core_clk_i, .rst_i, .bit_clk_i, .tx_en_i,
        .tx_er_i, .txd_i, .enc_enable_i, .adc_sample_i, .clk_phases_i, .phase_sel_i, .rx_mlt_i,
        .rx_group_i, .rx_group_valid_i, .tx_ready_o, .tx_mlt_o, .tx_nrzi_o, .adc_sample_o,
        .rec_clk_o, .rx_nrzi_o, .rxd_o, .rx_dv_o, .rx_er_o, .crs_o);
    mac_model u_mac (.clk_i(core_clk_i), .rst_i(rst_i), .start_i(mac_go), .err_i(mac_err),
        .tx_ready_i(tx_ready_o), .tx_en_o(tx_en_i), .tx_er_o(tx_er_i), .txd_o(txd_i));

    always #25 core_clk_i = ~core_clk_i;
    always #200 bit_clk_i = ~bit_clk_i;

    // Random line-side samples; held at zero in reset so history checks start clean
    always @(posedge core_clk_i) begin
        if (!rst_i) begin
            adc_sample_i <= 6'($urandom);
            clk_phases_i <= 4'($urandom);
            rx_mlt_i <= ($urandom % 3 == 2) ? 2'h3 : 2'($urandom % 2);
            if (tx_en_i && !tx_ready_o) full_seen <= 1'b1;
            if (tx_mlt_o != last_mlt) mlt_chg <= mlt_chg + 1;
            last_mlt <= tx_mlt_o;
        end
    end

    task automatic cmp_rx(input logic [5:0] got, input logic [5:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Note layout: {check rxd, rxd, rx_er, check crs, crs}
    always @(posedge core_clk_i) seen_q <= rx_group_valid_i;
    always @(negedge core_clk_i) begin
        if (seen_q) begin
            e = exq.pop_front();
            cmp_rx({rxd_o, rx_er_o, crs_o}, {e[7] ? e[6:3] : rxd_o, e[2], e[1] ? e[0] : crs_o});
        end
    end

    // Line receiver: one bit per coding-clock rise, keystream mirrored from the seed.
    // The first rise after reset only arms it, since no slot has gone out before it.
    logic armed = 1'b0, last_nrzi = 1'b0, mlt_up = 1'b1, kb, ok;
    logic [10:0] key_q = `SCR_SEED;
    logic [4:0] grp = 5'h00, p1 = `CG_IDLE, p2 = `CG_IDLE;
    logic [1:0] mlt_exp = `MLT_MID;
    int nb = 0, st = 0, n_j = 0, n_h = 0, n_bp = 0, j;
    always @(posedge bit_clk_i) begin
        if (armed && !rst_i) begin
            kb = key_q[`SCR_TAP_A] ^ key_q[`SCR_TAP_B];
            key_q = {key_q[9:0], kb};
            if (tx_nrzi_o != last_nrzi) begin
                if (mlt_exp == `MLT_MID) begin
                    mlt_exp = mlt_up ? `MLT_POS : `MLT_NEG;
                    mlt_up = ~mlt_up;
                end else begin
                    mlt_exp = `MLT_MID;
                end
            end
            cmp_rx({4'h0, tx_mlt_o}, {4'h0, mlt_exp});
            grp = {grp[3:0], tx_nrzi_o ^ last_nrzi ^ kb};
            nb++;
            if (nb == 5) begin
                nb = 0;
                ok = (grp == `CG_H);
                for (j = 0; j < 16; j++) ok = ok | (grp == dtab[j]);
                if (st == 0 && grp == `CG_J) begin
                    st = 1;
                    n_j++;
                end else if (st == 0) begin
                    cmp_rx({1'b0, grp}, {1'b0, `CG_IDLE});
                end else if (st == 1) begin
                    cmp_rx({1'b0, grp}, {1'b0, `CG_K});
                    st = 2;
                end else if (st == 3) begin
                    cmp_rx({1'b0, grp}, {1'b0, `CG_R});
                    st = 4;
                end else if (st == 4) begin
                    cmp_rx({1'b0, grp}, {1'b0, `CG_IDLE});
                    st = 0;
                end else if (!enc_enable_i && grp == `CG_IDLE) begin
                    cmp_bit({p2, p1} == {`CG_T, `CG_R}, 1'b1);
                    st = 0;
                end else if (!enc_enable_i) begin
                    cmp_bit(grp[4], 1'b0);
                    n_bp++;
                end else if (grp == `CG_T) begin
                    st = 3;
                end else begin
                    cmp_bit(ok, 1'b1);
                    if (grp == `CG_H) n_h++;
                end
                p2 = p1;
                p1 = grp;
            end
        end
        armed = !rst_i;
        last_nrzi = tx_nrzi_o;
    end

    task automatic send(input logic [4:0] g, input logic [7:0] x);
        rx_group_i <= g;
        rx_group_valid_i <= 1'b1;
        exq.push_back(x);
        @(posedge core_clk_i);
        rx_group_valid_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
    endtask

    task automatic opn;
        send(`CG_IDLE, 8'h00);
        send(`CG_IDLE, 8'h02);
        send(`CG_J, 8'hA8);
        send(`CG_K, 8'hA8);
    endtask

    task automatic tx_frame;
        mac_go <= 1'b1;
        @(posedge core_clk_i);
        mac_go <= 1'b0;
        for (k = 0; k < 3000 && (tx_en_i || k < 4); k++) @(posedge core_clk_i);
        cmp_bit(k < 3000, 1'b1);
        repeat (400) @(posedge core_clk_i); // Let T, R and idle reach the line
    endtask

    task give_verdict;
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h5c87));
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        opn();
        cmp_bit(rx_dv_o, 1'b1);
        r = 4'($urandom);
        for (i = 0; i < 16; i++) send(dtab[i[3:0] ^ r], {1'b1, i[3:0] ^ r, 3'b000});
        send(`CG_T, 8'h00);
        send(`CG_R, 8'h02);
        cmp_bit(rx_dv_o, 1'b0);
        for (i = 0; i < 10; i++) begin
            opn();
            send(bad[i], 8'h04);
        end
        opn();
        send(`CG_J, 8'h04);
        opn();
        send(dtab[3], 8'h98);
        send(`CG_R, 8'h04);
        send(`CG_IDLE, 8'h00);
        send(`CG_IDLE, 8'h02);
        send(`CG_K, 8'hF4);
        opn();
        send(`CG_T, 8'h00);
        send(dtab[0], 8'h04);
        cmp_bit(mlt_chg > 0, 1'b1);
        // Frame with a transmit error, then one with encoding bypassed
        mac_err <= 1'b1;
        tx_frame();
        cmp_bit(full_seen, 1'b1);
        cmp_bit(n_h > 0, 1'b1);
        cmp_bit(n_j == 1, 1'b1);
        enc_enable_i <= 1'b0;
        phase_sel_i <= 2'h2;
        mac_err <= 1'b0;
        tx_frame();
        cmp_bit(tx_en_i, 1'b0);
        cmp_bit(n_bp > 0, 1'b1);
        cmp_bit(st == 0 && n_j == 2, 1'b1);
        repeat (10) @(posedge core_clk_i);
        cmp_bit(exq.size() == 0, 1'b1);
        give_verdict();
    end

    // Longest run is under 2000 cycles; ten times that means a hang
    initial begin
        repeat (20000) @(posedge core_clk_i);
        error_cnt++;
        give_verdict();
    end
endmodule

// ===== verification/mac_model.sv
`timescale 1ns/100ps
module mac_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic err_i,
    input wire logic tx_ready_i,
    output logic tx_en_o,
    output logic tx_er_o,
    output logic [3:0] txd_o
);
    logic [3:0] cnt_q;
    // Nibble held until ready is seen high; nibbles sent before ready drops still reach a full buffer and are lost
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_en_o <= 1'b0;
            tx_er_o <= 1'b0;
            txd_o <= 4'h0;
            cnt_q <= 4'h0;
        end else if (!tx_en_o) begin
            txd_o <= start_i ? 4'h0 : ~txd_o; // Idle lines toggle between the last nibble and its inverse
            tx_er_o <= 1'b0;
            if (start_i) begin
                tx_en_o <= 1'b1;
                cnt_q <= 4'h0;
            end
        end else if (tx_ready_i) begin
            cnt_q <= cnt_q + 4'h1;
            txd_o <= cnt_q + 4'h1;
            tx_er_o <= err_i && (cnt_q == 4'h5);
            if (cnt_q == 4'hB) begin
                tx_en_o <= 1'b0;
            end
        end
    end
endmodule
